// ==== logic/expander_pkg.sv ====
// Constants, offsets, reset values and types shared by the port expander.
package expander_pkg;

    // ****************************************************************
    // Address and command layout
    // ****************************************************************
    // Fixed upper four bits of the seven-bit slave address.
    localparam logic [3:0] addr_fixed      = 4'h4;
    // General call address, never answered.
    localparam logic [6:0] addr_general    = 7'h00;
    // Width of the register select field in the command byte.
    localparam int         sel_width       = 3;
    // Bits per serial byte.
    localparam logic [3:0] byte_bits       = 4'h8;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [2:0] reg_in0         = 3'h0;
    localparam logic [2:0] reg_in1         = 3'h1;
    localparam logic [2:0] reg_out0        = 3'h2;
    localparam logic [2:0] reg_out1        = 3'h3;
    localparam logic [2:0] reg_inv0        = 3'h4;
    localparam logic [2:0] reg_inv1        = 3'h5;
    localparam logic [2:0] reg_dir0        = 3'h6;
    localparam logic [2:0] reg_dir1        = 3'h7;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] out_reset       = 8'hff;
    localparam logic [7:0] inv_reset       = 8'h00;
    localparam logic [7:0] dir_reset       = 8'hff;
    localparam logic [7:0] ptr_reset       = 8'h00;

    // ****************************************************************
    // Timing
    // ****************************************************************
    // Glitch filter length in system clock cycles.
    localparam logic [1:0] filt_cycles     = 2'h3;

    // Serial engine states.
    typedef enum logic [4:0] {
        st_idle = 5'b00001,
        st_recv = 5'b00010,
        st_ack  = 5'b00100,
        st_send = 5'b01000,
        st_mack = 5'b10000
    } link_state_e;

endpackage : expander_pkg

// ==== logic/line_filter.sv ====
// Two-flop synchroniser followed by a stability filter that needs filt_cycles consecutive equal samples.
`timescale 1ns/1ps
module line_filter
    import expander_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic raw,
    output logic      clean
);

    // ****************************************************************
    // Filter state
    // ****************************************************************
    typedef struct packed {
        logic       s1;    // First synchroniser stage, read only by s2.
        logic       s2;    // Second synchroniser stage.
        logic [1:0] cnt;   // Cycles the new level has been seen.
        logic       out;   // Filtered level.
    } filt_s;

    filt_s r;       // Registered state.
    filt_s next_r;  // Next state.

    // The filtered level only follows a level held filt_cycles cycles.
    // This trades a few cycles of latency for immunity to short spikes.
    always_comb begin
        next_r    = r;
        next_r.s1 = raw;
        next_r.s2 = r.s1;
        if (r.s2 == r.out) begin
            next_r.cnt = 2'h0;
        end else if (r.cnt == filt_cycles - 2'h1) begin
            next_r.out = r.s2;
            next_r.cnt = 2'h0;
        end else begin
            next_r.cnt = r.cnt + 2'h1;
        end
    end

    // Lines idle high, so reset to high to avoid a false edge.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            r <= '{s1: 1'b1, s2: 1'b1, cnt: 2'h0, out: 1'b1};
        end else begin
            r <= next_r;
        end
    end

    assign clean = r.out;

endmodule : line_filter

// ==== logic/port_expander.sv ====
// Two-wire serial slave and register bank of a 16-bit port expander.
`timescale 1ns/1ps
module port_expander
    import expander_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic [2:0] addr_strap_pins,
    input  wire logic [7:0] port0_pins_in,
    input  wire logic [7:0] port1_pins_in,
    output logic      [7:0] port0_pins_out,
    output logic      [7:0] port0_pins_oe,
    output logic      [7:0] port1_pins_out,
    output logic      [7:0] port1_pins_oe,
    output logic            int_n
);

    // ****************************************************************
    // Line conditioning
    // ****************************************************************
    logic scl_f;  // Filtered clock line.
    logic sda_f;  // Filtered data line.

    line_filter u_scl (
        .clk   (clk),
        .rstn  (rstn),
        .raw   (scl_in),
        .clean (scl_f)
    );

    line_filter u_sda (
        .clk   (clk),
        .rstn  (rstn),
        .raw   (sda_in),
        .clean (sda_f)
    );

    // ****************************************************************
    // State of the whole block
    // ****************************************************************
    typedef struct packed {
        link_state_e  st;       // Serial engine state.
        logic         scl_d;    // Previous filtered clock.
        logic         sda_d;    // Previous filtered data.
        logic [3:0]   bitn;     // Bits taken in the current byte.
        logic [7:0]   shift;    // Receive or transmit shift register.
        logic         is_addr;  // Next received byte is an address.
        logic         is_cmd;   // Next written byte is the command.
        logic         rd;       // Current transfer is a read.
        logic         nack;     // Master did not acknowledge.
        logic [7:0]   ptr;      // Command byte, low bits select.
        logic [7:0]   out0;     // Output latch port 0.
        logic [7:0]   out1;     // Output latch port 1.
        logic [7:0]   inv0;     // Polarity inversion port 0.
        logic [7:0]   inv1;     // Polarity inversion port 1.
        logic [7:0]   dir0;     // Direction port 0, one is input.
        logic [7:0]   dir1;     // Direction port 1, one is input.
        logic [18:0]  p_s1;     // Strap and pin synchroniser, stage one.
        logic [18:0]  p_s2;     // Strap and pin synchroniser, stage two.
        logic [15:0]  snap;     // Pin levels last reported.
        logic         sda_oe;   // Data line pull-down enable.
        logic         int_n;    // Interrupt output, low active.
        logic [15:0]  p_out;    // Registered pin drive levels.
        logic [15:0]  p_oe;     // Registered pin drive enables.
    } blk_s;

    blk_s r;       // Registered state.
    blk_s next_r;  // Next state.

    // ****************************************************************
    // Combinational helpers
    // ****************************************************************
    logic        scl_rise;   // Clock rising edge.
    logic        scl_fall;   // Clock falling edge.
    logic        start_det;  // Start or repeated start.
    logic        stop_det;   // Stop.
    logic [6:0]  own_addr;   // This device's address.
    logic [15:0] in_now;     // Synchronised pin levels.
    logic [15:0] changed;    // Input pins differing from snapshot.

    assign scl_rise  = scl_f & ~r.scl_d;
    assign scl_fall  = ~scl_f & r.scl_d;
    assign start_det = scl_f & r.scl_d & r.sda_d & ~sda_f;
    assign stop_det  = scl_f & r.scl_d & ~r.sda_d & sda_f;
    // strap address
    // Straps are pins too, so they are read only after synchronising.
    assign own_addr  = {addr_fixed, r.p_s2[18:16]};
    assign in_now    = r.p_s2[15:0];
    assign changed   = (in_now ^ r.snap) & {r.dir1, r.dir0};

    // Reads the selected register; input registers apply inversion.
    function automatic logic [7:0] read_reg(input blk_s s,
                                            input logic [2:0] sel);
        logic [7:0] v;
        v = 8'h00;
        unique case (sel)
            reg_in0:  v = s.p_s2[7:0] ^ s.inv0;
            reg_in1:  v = s.p_s2[15:8] ^ s.inv1;
            reg_out0: v = s.out0;
            reg_out1: v = s.out1;
            reg_inv0: v = s.inv0;
            reg_inv1: v = s.inv1;
            reg_dir0: v = s.dir0;
            reg_dir1: v = s.dir1;
        endcase
        return v;
    endfunction : read_reg

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // The engine samples data on clock rise and changes its own drive
    // only on clock fall, so the line is stable while clock is high.
    always_comb begin
        next_r       = r;
        next_r.scl_d = scl_f;
        next_r.sda_d = sda_f;
        next_r.p_s1  = {addr_strap_pins, port1_pins_in, port0_pins_in};
        next_r.p_s2  = r.p_s1;

        if (|changed) begin
            next_r.int_n = 1'b0;
        end else begin
            next_r.int_n = 1'b1;
        end

        if (start_det) begin
            next_r.st      = st_recv;
            next_r.bitn    = 4'h0;
            next_r.is_addr = 1'b1;
            next_r.sda_oe  = 1'b0;
        end else if (stop_det) begin
            next_r.st     = st_idle;
            next_r.sda_oe = 1'b0;
        end else begin
            unique case (r.st)
                st_idle: begin
                    next_r.sda_oe = 1'b0;
                end
                st_recv: begin
                    if (scl_rise) begin
                        next_r.shift = {r.shift[6:0], sda_f};
                        next_r.bitn  = r.bitn + 4'h1;
                    end
                    if (scl_fall && r.bitn == byte_bits) begin
                        next_r.bitn = 4'h0;
                        if (r.is_addr) begin
                            if (r.shift[7:1] == own_addr &&
                                r.shift[7:1] != addr_general) begin
                                next_r.sda_oe  = 1'b1;
                                next_r.st      = st_ack;
                                next_r.is_addr = 1'b0;
                                next_r.rd      = r.shift[0];
                                next_r.is_cmd  = ~r.shift[0];
                            end else begin
                                next_r.st = st_idle;
                            end
                        end else begin
                            next_r.sda_oe = 1'b1;
                            next_r.st     = st_ack;
                            if (r.is_cmd) begin
                                next_r.ptr    = r.shift;
                                next_r.is_cmd = 1'b0;
                            end else begin
                                unique case (r.ptr[2:0])
                                    reg_out0: next_r.out0 = r.shift;
                                    reg_out1: next_r.out1 = r.shift;
                                    reg_inv0: next_r.inv0 = r.shift;
                                    reg_inv1: next_r.inv1 = r.shift;
                                    reg_dir0: next_r.dir0 = r.shift;
                                    reg_dir1: next_r.dir1 = r.shift;
                                    default: ;
                                endcase
                                next_r.ptr[0] = ~r.ptr[0];
                            end
                        end
                    end
                end
                st_ack: begin
                    // At the end of the acknowledge pulse, release for a write or drive the first read bit.
                    if (scl_fall) begin
                        if (r.rd) begin
                            next_r.shift = read_reg(r, r.ptr[2:0]);
                            next_r.sda_oe = ~next_r.shift[7];
                            next_r.bitn  = 4'h1;
                            next_r.st    = st_send;
                        end else begin
                            next_r.sda_oe = 1'b0;
                            next_r.st     = st_recv;
                        end
                    end
                end
                st_send: begin
                    if (scl_fall) begin
                        if (r.bitn == byte_bits) begin
                            next_r.sda_oe = 1'b0;
                            next_r.st     = st_mack;
                        end else begin
                            next_r.sda_oe = ~r.shift[6];
                            next_r.shift  = {r.shift[6:0], 1'b0};
                            next_r.bitn   = r.bitn + 4'h1;
                        end
                    end
                end
                st_mack: begin
                    if (scl_rise) begin
                        next_r.nack = sda_f;
                        if (r.ptr[2:0] == reg_in0) begin
                            next_r.snap[7:0] = in_now[7:0];
                        end
                        if (r.ptr[2:0] == reg_in1) begin
                            next_r.snap[15:8] = in_now[15:8];
                        end
                        next_r.ptr[0] = ~r.ptr[0];
                    end
                    if (scl_fall) begin
                        if (r.nack) begin
                            next_r.st = st_idle;
                        end else begin
                            next_r.shift  = read_reg(r, r.ptr[2:0]);
                            next_r.sda_oe = ~next_r.shift[7];
                            next_r.bitn   = 4'h1;
                            next_r.st     = st_send;
                        end
                    end
                end
                default: next_r.st = st_idle;
            endcase
        end

        next_r.p_out = {next_r.out1, next_r.out0};
        next_r.p_oe  = ~{next_r.dir1, next_r.dir0};
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Snapshot starts at zero; the first sampled inputs may raise the
    // interrupt, which a read of each input register then clears.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            r         <= '0;
            r.st      <= st_idle;
            r.scl_d   <= 1'b1;
            r.sda_d   <= 1'b1;
            r.is_addr <= 1'b1;
            r.ptr     <= ptr_reset;
            r.out0    <= out_reset;
            r.out1    <= out_reset;
            r.inv0    <= inv_reset;
            r.inv1    <= inv_reset;
            r.dir0    <= dir_reset;
            r.dir1    <= dir_reset;
            r.int_n   <= 1'b1;
            r.p_out   <= {out_reset, out_reset};
        end else begin
            r <= next_r;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign sda_out        = 1'b0;
    assign sda_oe         = r.sda_oe;
    assign int_n          = r.int_n;
    assign port0_pins_out = r.p_out[7:0];
    assign port1_pins_out = r.p_out[15:8];
    assign port0_pins_oe  = r.p_oe[7:0];
    assign port1_pins_oe  = r.p_oe[15:8];

endmodule : port_expander

// ==== bench/expander_assertions.sv ====
// Concurrent checks on the port expander's serial and pin outputs.
`timescale 1ns/1ps
module expander_checker (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [7:0] port0_pins_out,
    input wire logic [7:0] port0_pins_oe,
    input wire logic [7:0] port1_pins_out,
    input wire logic [7:0] port1_pins_oe,
    input wire logic       int_n
);
    // ****************************************************************
    // All checks sit in the system clock domain.
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    AST_RESET_STATE: assert property (
        $rose(rstn) |-> int_n && !sda_oe && port0_pins_oe == 8'h00
            && port1_pins_oe == 8'h00 && port0_pins_out == 8'hff)
        else $error("outputs not at reset values");
    AST_OPEN_DRAIN: assert property (
        sda_oe |-> sda_out == 1'b0)
        else $error("data line driven high");
    AST_OE_CLOCK_LOW: assert property (
        $changed(sda_oe) |-> !$past(scl_in))
        else $error("data drive changed while clock high");
    AST_OE_HELD_HIGH: assert property (
        $rose(scl_in) && sda_oe |-> sda_oe [*8])
        else $error("data drive dropped in clock high");
    AST_START_QUIET: assert property (
        scl_in && $past(scl_in) && $fell(sda_in) |-> !sda_oe [*8])
        else $error("data driven right after start");
    AST_STOP_IDLE: assert property (
        scl_in && $rose(sda_in) |=> !sda_oe [*8])
        else $error("data driven right after stop");
    AST_LATCH_CLOCK_LOW: assert property (
        $changed({port0_pins_out, port1_pins_out}) |-> !$past(scl_in))
        else $error("output latch changed while clock high");
    AST_DIR_CLOCK_LOW: assert property (
        $changed({port0_pins_oe, port1_pins_oe}) |-> !$past(scl_in))
        else $error("pin direction changed while clock high");
endmodule : expander_checker

bind port_expander expander_checker expander_checker_i (
    .clk, .rstn, .scl_in, .sda_in, .sda_out, .sda_oe, .port0_pins_out,
    .port0_pins_oe, .port1_pins_out, .port1_pins_oe, .int_n
);

// ==== bench/master_model.sv ====
// Behavioural two-wire bus master that drives the expander's serial pins.
`timescale 1ns/1ps
module master_model #(
    // Quarter of the 125 ns bus clock period.
    parameter realtime QTR = 31.25
) (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    // Both lines start released; the pull-ups keep the bus idle high.
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // data moves only while clock low.
    task automatic bit_cycle(input logic b, output logic s);
        sda_pull = ~b;
        #QTR scl = 1'b1;
        #QTR s = sda;
        #QTR scl = 1'b0;
        #QTR;
    endtask : bit_cycle
    // start, also repeated, from a released data line.
    task automatic start();
        sda_pull = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_pull = 1'b1;
        #QTR scl = 1'b0;
        #QTR;
    endtask : start
    // stop leaves both lines released, so the clock stands high.
    task automatic stop();
        sda_pull = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_pull = 1'b0;
        #QTR;
    endtask : stop
    // most significant bit first, released for acknowledge.
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], s);
        end
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask : write_byte
    // acknowledge all but the last byte read.
    task automatic read_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, d[i]);
        end
        bit_cycle(~mack, s);
    endtask : read_byte
endmodule : master_model

// ==== bench/tb.sv ====
// Self-checking bench for the port expander driven by a modelled master.
`timescale 1ns/1ps
module tb;
    import expander_pkg::*;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       scl;
    logic       sda_pull;
    logic       sda;
    logic       sda_out;
    logic       sda_oe;
    logic [2:0] strap;
    logic [7:0] ext0;
    logic [7:0] ext1;
    logic [7:0] p0_in;
    logic [7:0] p1_in;
    logic [7:0] p0_out;
    logic [7:0] p0_oe;
    logic [7:0] p1_out;
    logic [7:0] p1_oe;
    logic       int_n;
    logic       ack;
    int         mismatches = 0;
    int         check_count = 0;
    int         cycles = 0;

    always #5 clk = ~clk;
    // Wired-AND data line with pull-up; pins follow their drivers.
    assign sda = ~sda_pull & (~sda_oe | sda_out);
    assign p0_in = (p0_oe & p0_out) | (~p0_oe & ext0);
    assign p1_in = (p1_oe & p1_out) | (~p1_oe & ext1);

    master_model master_model_i (.scl(scl), .sda_pull(sda_pull), .sda(sda));
    port_expander port_expander_i (
        .clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_pins(strap),
        .port0_pins_in(p0_in), .port1_pins_in(p1_in),
        .port0_pins_out(p0_out), .port0_pins_oe(p0_oe),
        .port1_pins_out(p1_out), .port1_pins_oe(p1_oe), .int_n(int_n)
    );

    task automatic give_verdict();
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // A hung handshake ends the run here instead of stalling forever.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Address byte alone, then stop; the answer is left in ack.
    task automatic probe(input logic [6:0] a);
        master_model_i.start();
        master_model_i.write_byte({a, 1'b0}, ack);
        master_model_i.stop();
    endtask : probe

    // Command byte plus n data bytes, each of which must be acknowledged.
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d [4],
                      input int n);
        probe_start(1'b0);
        master_model_i.write_byte(cmd, ack);
        check("command ack", ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            master_model_i.write_byte(d[i], ack);
            check("data ack", ack, 1'b1);
        end
        master_model_i.stop();
    endtask : wr

    task automatic probe_start(input logic rd);
        master_model_i.start();
        master_model_i.write_byte({addr_fixed, strap, rd}, ack);
        check("own address ack", ack, 1'b1);
    endtask : probe_start

    // Reads n bytes from the held pointer; the last one is refused.
    task automatic rd_chk(input logic [7:0] e [4], input int n);
        logic [7:0] v;
        probe_start(1'b1);
        for (int i = 0; i < n; i++) begin
            master_model_i.read_byte(i < n - 1, v);
            check("read data", v, e[i]);
        end
        // Give the device time to act on the refusal before looking.
        repeat (8) @(negedge clk);
        check("data released", sda, 1'b1);
        master_model_i.stop();
    endtask : rd_chk

    task automatic t_reset_values();
        logic [7:0] v;
        check("port0 oe", p0_oe, 8'h00);
        check("port1 out", p1_out, out_reset);
        for (int k = 1; k < 4; k++) begin
            v = (k == 1) ? out_reset : (k == 2) ? inv_reset : dir_reset;
            wr({5'h00, k[1:0], 1'b0}, '{8'h00, 8'h00, 8'h00, 8'h00}, 0);
            rd_chk('{v, v, 8'h00, 8'h00}, 2);
        end
    endtask : t_reset_values

    task automatic t_address();
        for (int s = 0; s < 8; s++) begin
            @(negedge clk);
            strap = s[2:0];
            probe({addr_fixed, s[2:0]});
            check("match ack", ack, 1'b1);
            probe({addr_fixed, s[2:0] + 3'h1});
            check("other address", ack, 1'b0);
        end
        probe(addr_general);
        check("general call", ack, 1'b0);
        @(negedge clk);
        strap = 3'h5;
    endtask : t_address

    task automatic t_write_regs();
        wr({5'h00, reg_dir0}, '{8'h0f, 8'hf0, 8'h00, 8'h00}, 2);
        wr({5'h00, reg_out1}, '{8'h5a, 8'ha5, 8'h3c, 8'h00}, 3);
        check("port0 oe", p0_oe, 8'hf0);
        check("port1 oe", p1_oe, 8'h0f);
        check("port0 out", p0_out, 8'ha5);
        check("port1 out", p1_out, 8'h3c);
    endtask : t_write_regs

    task automatic t_inputs();
        logic [7:0] e0;
        logic [7:0] e1;
        e0 = ((8'ha5 & 8'hf0) | (ext0 & 8'h0f)) ^ 8'h33;
        e1 = (8'h3c & 8'h0f) | (ext1 & 8'hf0);
        wr({5'h00, reg_inv0}, '{8'h33, inv_reset, 8'h00, 8'h00}, 2);
        wr({5'h00, reg_in0}, '{8'h00, 8'h00, 8'h00, 8'h00}, 2);
        rd_chk('{e0, e1, e0, 8'h00}, 3);
        rd_chk('{e1, 8'h00, 8'h00, 8'h00}, 1);
    endtask : t_inputs

    task automatic t_interrupt();
        check("int idle", int_n, 1'b1);
        wr({5'h00, reg_out0}, '{8'h5a, 8'h00, 8'h00, 8'h00}, 1);
        check("int output pin", int_n, 1'b1);
        for (int k = 0; k < 2; k++) begin
            @(negedge clk);
            ext0 = ext0 ^ 8'h01;
            repeat (20) @(negedge clk);
            check("int input edge", int_n, k[0]);
        end
        @(negedge clk);
        ext0 = ext0 ^ 8'h02;
        wr({5'h00, reg_in1}, '{8'h00, 8'h00, 8'h00, 8'h00}, 0);
        rd_chk('{(8'h3c & 8'h0f) | (ext1 & 8'hf0), 8'h00, 8'h00, 8'h00}, 1);
        check("int other port", int_n, 1'b0);
        wr({5'h00, reg_in0}, '{8'h00, 8'h00, 8'h00, 8'h00}, 0);
        rd_chk('{((8'h5a & 8'hf0) | (ext0 & 8'h0f)) ^ 8'h33, 8'h00, 8'h00,
                 8'h00}, 1);
        check("int port read", int_n, 1'b1);
    endtask : t_interrupt

    // Main sequence; the filters need the idle bus for a few cycles.
    initial begin
        strap = 3'h0;
        ext0 = 8'h0c;
        ext1 = 8'h90;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        repeat (10) @(negedge clk);
        t_reset_values();
        t_address();
        t_write_regs();
        t_inputs();
        t_interrupt();
        give_verdict();
    end
endmodule : tb
